// ---- core/sec_cmd_pkg.sv ----
// shared constants for the security command link and its two ends
package sec_cmd_pkg;
  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_DISABLE_PWD = 8'hF6;
  localparam logic [7:0] OP_ERASE_PREP  = 8'hF3;
  localparam logic [7:0] OP_ERASE_UNIT  = 8'hF4;
  // ----------------------------------------------------------------
  // data sector layout, in 16-bit words
  // ----------------------------------------------------------------
  localparam int         SECTOR_WORDS  = 256;
  localparam logic [7:0] W_CTRL        = 8'h00;
  localparam logic [7:0] W_PWD_FIRST   = 8'h01;
  localparam logic [7:0] W_PWD_LAST    = 8'h10;
  localparam logic [7:0] W_SECTOR_LAST = 8'hFF;
  localparam int         CTRL_SEL_BIT  = 0;
  localparam int         PWD_BITS      = 256;
  // ----------------------------------------------------------------
  // error and status flag positions
  // ----------------------------------------------------------------
  localparam int ERR_ABORT_BIT = 2;
  localparam int ST_BUSY_BIT   = 7;
  localparam int ST_READY_BIT  = 6;
  localparam int ST_FAULT_BIT  = 5;
  localparam int ST_SEEK_BIT   = 4;
  localparam int ST_DREQ_BIT   = 3;
  localparam int ST_ERR_BIT    = 0;
  localparam logic [7:0] STATUS_RESET = 8'h50;
  localparam logic [7:0] ERROR_RESET  = 8'h00;
  // ----------------------------------------------------------------
  // controller register map (byte offsets)
  // ----------------------------------------------------------------
  localparam logic [5:0] REG_COMMAND  = 6'h00;
  localparam logic [5:0] REG_CTRLWORD = 6'h04;
  localparam logic [5:0] REG_RESULT   = 6'h08;
  localparam logic [5:0] REG_IRQ_STAT = 6'h0C;
  localparam logic [5:0] REG_IRQ_MASK = 6'h10;
  localparam logic [5:0] REG_PWD_BASE = 6'h20;
  localparam int RES_BUSY_BIT = 16;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ABRT_BIT = 1;
endpackage

// ---- core/sec_cmd_if.sv ----
// link between the command issuing controller and the drive end
`timescale 1ns/100ps
`default_nettype none
interface sec_cmd_if;
  logic        cmdValid;
  logic [7:0]  cmdCode;
  logic        wordValid;
  logic [15:0] wordData;
  logic        busy;
  logic        dataReq;
  logic        done;
  logic [7:0]  errorFlags;
  logic [7:0]  statusFlags;

  modport drive (
    input  cmdValid, cmdCode, wordValid, wordData,
    output busy, dataReq, done, errorFlags, statusFlags
  );
  modport ctrl (
    output cmdValid, cmdCode, wordValid, wordData,
    input  busy, dataReq, done, errorFlags, statusFlags
  );
endinterface
`default_nettype wire

// ---- core/sec_cmd_drive.sv ----
// drive end: disable-password and erase-prepare command handling
//
// Summary of operation
// (R01) opcode F6h starts disable password
// (R02) disable password takes exactly one data sector
// (R03) matching user or master password unlocks
// (R04) master password is never modified here
// (R05) host should disable only when unlocked
// (R06) lock off and user selected: abort
// (R07) control word bit 0 selects master
// (R08) words 1-16 hold 32-byte password
// (R09) opcode F3h arms erase preparation
// (R10) host issues prepare right before erase
// (R11) prepare completes with no data phase
// (R12) erase unit without armed prepare aborts
// (R13) abort sets abort and error flags
// (R14) any other command disarms the prepare
`timescale 1ns/100ps
`default_nettype none
module sec_cmd_drive #(
  parameter int PWD_W = sec_cmd_pkg::PWD_BITS
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  sec_cmd_if.drive              link,
  input  wire logic [PWD_W-1:0] userPwd,
  input  wire logic [PWD_W-1:0] masterPwd,
  input  wire logic             lockSet,
  output logic                  lockOn,
  output logic                  eraseGo
);
  // ----------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {IDLE, XFER, FINISH} drv_state_t;

  drv_state_t  state_r;
  logic [7:0]  cmd_r;
  logic [7:0]  wordCnt_r;
  logic        selMaster_r;
  logic        mismatch_r;
  logic        abort_r;
  logic        armed_r;
  logic        lockOn_r;
  logic        eraseGo_r;
  logic        done_r;
  logic [7:0]  errorFlags_r;
  logic [7:0]  statusFlags_r;
  logic        cmdTake;
  logic        wordTake;
  logic [15:0] expWord;

  // one 16-bit slice of a stored password, word 0 in the low bits
  function automatic logic [15:0] pwdSlice(
    input logic [PWD_W-1:0] pwd,
    input logic [7:0]       idx
  );
    logic [3:0] w;
    w = idx[3:0] - 4'h1;
    pwdSlice = pwd[{w, 4'h0} +: 16];
  endfunction

  // completion status word with or without the error summary
  function automatic logic [7:0] doneStatus(input logic failed);
    logic [7:0] s;
    s = 8'h00;
    s[sec_cmd_pkg::ST_READY_BIT] = 1'b1;
    s[sec_cmd_pkg::ST_SEEK_BIT]  = 1'b1;
    s[sec_cmd_pkg::ST_ERR_BIT]   = failed;
    doneStatus = s;
  endfunction

  // commands are taken only while idle, words only in the data phase
  assign cmdTake  = link.cmdValid && (state_r == IDLE);
  assign wordTake = link.wordValid && (state_r == XFER);
  // compare against the password the control word selected
  assign expWord  = selMaster_r ? pwdSlice(masterPwd, wordCnt_r)
                                : pwdSlice(userPwd, wordCnt_r);

  // ----------------------------------------------------------------
  // command sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= IDLE;
      cmd_r   <= 8'h00;
      abort_r <= 1'b0;
    end else begin
      unique case (state_r)
        IDLE: begin
          if (cmdTake) begin
            cmd_r <= link.cmdCode;
            if (link.cmdCode == sec_cmd_pkg::OP_DISABLE_PWD) begin // R01
              state_r <= XFER; // R02
              abort_r <= 1'b0;
            end else if (link.cmdCode == sec_cmd_pkg::OP_ERASE_PREP) begin
              state_r <= FINISH; // R11
              abort_r <= 1'b0;
            end else if (link.cmdCode == sec_cmd_pkg::OP_ERASE_UNIT) begin
              state_r <= FINISH;
              abort_r <= !armed_r; // R12
            end else begin
              state_r <= FINISH; // unsupported here: aborted
              abort_r <= 1'b1;
            end
          end
        end
        XFER: begin
          // verdict after the last word of the single sector
          if (wordTake && wordCnt_r == sec_cmd_pkg::W_SECTOR_LAST) begin
            state_r <= FINISH; // R02
            abort_r <= mismatch_r || (!lockOn_r && !selMaster_r); // R06
          end
        end
        FINISH: state_r <= IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sector receive and password compare
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      wordCnt_r   <= 8'h00;
      selMaster_r <= 1'b0;
      mismatch_r  <= 1'b0;
    end else if (cmdTake) begin
      wordCnt_r  <= 8'h00;
      mismatch_r <= 1'b0;
    end else if (wordTake) begin
      wordCnt_r <= wordCnt_r + 8'h01;
      if (wordCnt_r == sec_cmd_pkg::W_CTRL) begin
        // bits 1-15 are reserved and ignored
        selMaster_r <= link.wordData[sec_cmd_pkg::CTRL_SEL_BIT]; // R07
      end else if (wordCnt_r >= sec_cmd_pkg::W_PWD_FIRST &&
                   wordCnt_r <= sec_cmd_pkg::W_PWD_LAST) begin
        if (link.wordData != expWord) begin
          mismatch_r <= 1'b1; // R08
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // lock function and prepare arming
  // ----------------------------------------------------------------
  // stored passwords are inputs only; nothing here rewrites them
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lockOn_r <= 1'b0;
    end else if (lockSet) begin
      lockOn_r <= 1'b1;
    end else if (state_r == FINISH && !abort_r &&
                 cmd_r == sec_cmd_pkg::OP_DISABLE_PWD) begin
      lockOn_r <= 1'b0; // R03 R04
    end
  end

  // armed only by a prepare, cleared by the next command that is not a prepare
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      armed_r <= 1'b0;
    end else if (cmdTake) begin
      armed_r <= (link.cmdCode == sec_cmd_pkg::OP_ERASE_PREP); // R09 R14
    end
  end

  // one-cycle start for the erase engine on an accepted erase unit
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      eraseGo_r <= 1'b0;
    end else begin
      eraseGo_r <= (state_r == FINISH) && !abort_r &&
                   (cmd_r == sec_cmd_pkg::OP_ERASE_UNIT); // R10
    end
  end

  // ----------------------------------------------------------------
  // error and status flags, completion strobe
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      errorFlags_r  <= sec_cmd_pkg::ERROR_RESET;
      statusFlags_r <= sec_cmd_pkg::STATUS_RESET;
      done_r        <= 1'b0;
    end else begin
      done_r <= (state_r == FINISH);
      if (cmdTake) begin
        errorFlags_r  <= 8'h00;
        statusFlags_r <= 8'h00;
        if (link.cmdCode == sec_cmd_pkg::OP_DISABLE_PWD) begin
          statusFlags_r[sec_cmd_pkg::ST_DREQ_BIT]  <= 1'b1; // R02
          statusFlags_r[sec_cmd_pkg::ST_READY_BIT] <= 1'b1;
        end else begin
          statusFlags_r[sec_cmd_pkg::ST_BUSY_BIT] <= 1'b1;
        end
      end else if (wordTake &&
                   wordCnt_r == sec_cmd_pkg::W_SECTOR_LAST) begin
        statusFlags_r <= 8'h00;
        statusFlags_r[sec_cmd_pkg::ST_BUSY_BIT] <= 1'b1;
      end else if (state_r == FINISH) begin
        // busy and fault stay clear on every completion
        errorFlags_r <= 8'h00;
        errorFlags_r[sec_cmd_pkg::ERR_ABORT_BIT] <= abort_r; // R13
        statusFlags_r <= doneStatus(abort_r); // R13
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.busy        = (state_r != IDLE) || done_r;
  assign link.dataReq     = (state_r == XFER);
  assign link.done        = done_r;
  assign link.errorFlags  = errorFlags_r;
  assign link.statusFlags = statusFlags_r;
  assign lockOn           = lockOn_r;
  assign eraseGo          = eraseGo_r;
endmodule
`default_nettype wire

// ---- core/sec_cmd_ctrl.sv ----
// controller end: Wishbone registers, command issue and sector send
`timescale 1ns/100ps
`default_nettype none
module sec_cmd_ctrl (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  sec_cmd_if.ctrl          link,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [5:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {C_IDLE, C_ISSUE, C_WAIT} ctl_state_t;

  ctl_state_t  state_r;
  logic [7:0]  opcode_r;
  logic [15:0] ctrlWord_r;
  logic [31:0] pwd_r [8];
  logic [7:0]  resErr_r;
  logic [7:0]  resStat_r;
  logic [1:0]  irqStat_r;
  logic [1:0]  irqMask_r;
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [8:0]  sent_r;
  logic        wordValid_r;
  logic [15:0] wordData_r;
  logic        wrHit;
  logic        rdHit;
  logic        startReq;
  logic [15:0] nextWord;
  logic [1:0]  irqSet;
  logic [3:0]  pIdx;

  // merge a write into a register through its byte lanes
  function automatic logic [31:0] laneMerge(
    input logic [31:0] old,
    input logic [31:0] dat,
    input logic [3:0]  sel
  );
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = sel[i] ? dat[8*i +: 8] : old[8*i +: 8];
    end
    laneMerge = old;
  endfunction

  // ----------------------------------------------------------------
  // wishbone slave: one wait state, ack for every address
  // ----------------------------------------------------------------
  assign wrHit    = wb_cyc_i && wb_stb_i && !ack_r && wb_we_i;
  assign rdHit    = wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i;
  assign startReq = wrHit && (wb_adr_i == sec_cmd_pkg::REG_COMMAND) &&
                    wb_sel_i[0] && (state_r == C_IDLE);
  assign irqSet   = {link.done && link.errorFlags[sec_cmd_pkg::ERR_ABORT_BIT],
                     link.done && (state_r == C_WAIT)};
  assign pIdx     = sent_r[3:0] - 4'h1;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
    end
  end

  // read data captured with the request, held with ack
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_r <= 32'h0000_0000;
    end else if (rdHit) begin
      rdat_r <= 32'h0000_0000;
      unique case (wb_adr_i)
        sec_cmd_pkg::REG_COMMAND:  rdat_r[7:0]  <= opcode_r;
        sec_cmd_pkg::REG_CTRLWORD: rdat_r[15:0] <= ctrlWord_r;
        sec_cmd_pkg::REG_RESULT: begin
          rdat_r[sec_cmd_pkg::RES_BUSY_BIT] <= (state_r != C_IDLE);
          rdat_r[15:0] <= {resErr_r, resStat_r};
        end
        sec_cmd_pkg::REG_IRQ_STAT: rdat_r[1:0] <= irqStat_r;
        sec_cmd_pkg::REG_IRQ_MASK: rdat_r[1:0] <= irqMask_r;
        default: begin
          if (wb_adr_i[5] == 1'b1) begin
            rdat_r <= pwd_r[wb_adr_i[4:2]];
          end
        end
      endcase
    end
  end

  // software-written configuration registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      opcode_r   <= 8'h00;
      ctrlWord_r <= 16'h0000;
      irqMask_r  <= 2'h0;
      for (int i = 0; i < 8; i++) begin
        pwd_r[i] <= 32'h0000_0000;
      end
    end else if (wrHit) begin
      if (wb_adr_i == sec_cmd_pkg::REG_COMMAND && wb_sel_i[0]) begin
        opcode_r <= wb_dat_i[7:0];
      end else if (wb_adr_i == sec_cmd_pkg::REG_CTRLWORD) begin
        ctrlWord_r <= 16'(laneMerge({16'h0000, ctrlWord_r}, wb_dat_i,
                                    wb_sel_i));
      end else if (wb_adr_i == sec_cmd_pkg::REG_IRQ_MASK && wb_sel_i[0]) begin
        irqMask_r <= wb_dat_i[1:0];
      end else if (wb_adr_i[5] == 1'b1) begin
        pwd_r[wb_adr_i[4:2]] <= laneMerge(pwd_r[wb_adr_i[4:2]], wb_dat_i,
                                          wb_sel_i);
      end
    end
  end

  // sticky events, write one to clear, a new event wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat_r <= 2'h0;
    end else begin
      if (wrHit && wb_adr_i == sec_cmd_pkg::REG_IRQ_STAT && wb_sel_i[0]) begin
        irqStat_r <= (irqStat_r & ~wb_dat_i[1:0]) | irqSet;
      end else begin
        irqStat_r <= irqStat_r | irqSet;
      end
    end
  end

  // ----------------------------------------------------------------
  // command issue and sector send
  // ----------------------------------------------------------------
  // software orders the commands, so prepare-before-erase and
  // disable-only-while-unlocked are kept by its sequence
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= C_IDLE;
      resErr_r  <= sec_cmd_pkg::ERROR_RESET;
      resStat_r <= sec_cmd_pkg::STATUS_RESET;
    end else begin
      unique case (state_r)
        C_IDLE:  if (startReq) state_r <= C_ISSUE; // R05 R10
        C_ISSUE: state_r <= C_WAIT; // R01 R09
        C_WAIT: begin
          if (link.done) begin
            state_r   <= C_IDLE;
            resErr_r  <= link.errorFlags;
            resStat_r <= link.statusFlags;
          end
        end
      endcase
    end
  end

  // sector word order: control word, password words, reserved zeros
  always_comb begin
    nextWord = 16'h0000;
    if (sent_r == 9'h000) begin
      nextWord = ctrlWord_r;
    end else if (sent_r <= {1'b0, sec_cmd_pkg::W_PWD_LAST}) begin
      nextWord = pwd_r[pIdx[3:1]][{pIdx[0], 4'h0} +: 16]; // R08
    end
  end

  // exactly one sector, one word a cycle while data is requested
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sent_r      <= 9'h000;
      wordValid_r <= 1'b0;
      wordData_r  <= 16'h0000;
    end else begin
      wordValid_r <= 1'b0;
      if (state_r == C_ISSUE) begin
        sent_r <= 9'h000;
      end else if (state_r == C_WAIT && link.dataReq &&
                   sent_r < 9'(sec_cmd_pkg::SECTOR_WORDS)) begin
        wordValid_r <= 1'b1; // R02
        wordData_r  <= nextWord;
        sent_r      <= sent_r + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign link.cmdValid  = (state_r == C_ISSUE);
  assign link.cmdCode   = opcode_r;
  assign link.wordValid = wordValid_r;
  assign link.wordData  = wordData_r;
  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = rdat_r;
  assign irq            = |(irqStat_r & irqMask_r);
endmodule
`default_nettype wire

// ---- test/sec_cmd_asserts.sv ----
// concurrent checks on the link between controller and drive
`timescale 1ns/100ps
`default_nettype none
module sec_cmd_asserts (
  input wire logic        ref_clk,
  input wire logic        rst_n,
  input wire logic        cmdValid,
  input wire logic [7:0]  cmdCode,
  input wire logic        wordValid,
  input wire logic [15:0] wordData,
  input wire logic        busy,
  input wire logic        dataReq,
  input wire logic        done,
  input wire logic [7:0]  errorFlags,
  input wire logic [7:0]  statusFlags
);
  logic       take;
  logic       known;
  logic [8:0] wordCnt_r;
  logic       armed_r;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // a command is taken only while the drive is idle
  assign take = cmdValid && !busy;
  assign known = cmdCode == sec_cmd_pkg::OP_DISABLE_PWD
              || cmdCode == sec_cmd_pkg::OP_ERASE_PREP
              || cmdCode == sec_cmd_pkg::OP_ERASE_UNIT;
  // counts sector words taken since the last command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      wordCnt_r <= 9'h000;
    else if (take)
      wordCnt_r <= 9'h000;
    else if (wordValid && dataReq)
      wordCnt_r <= wordCnt_r + 9'h001;
  end
  // erase arming follows the last taken opcode
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n)
      armed_r <= 1'b0;
    else if (take)
      armed_r <= cmdCode == sec_cmd_pkg::OP_ERASE_PREP;
  end
  f6_request_a: assert property (
    take && cmdCode == sec_cmd_pkg::OP_DISABLE_PWD |=> dataReq && statusFlags[3])
    else $error("no data request after disable opcode");
  sector_len_a: assert property (
    wordValid && dataReq && wordCnt_r == 9'h0FF
    |=> !dataReq && !done ##1 done)
    else $error("sector length or verdict timing wrong");
  prep_nodata_a: assert property (
    take && cmdCode == sec_cmd_pkg::OP_ERASE_PREP
    |=> !dataReq && !done ##1 (done && statusFlags == 8'h50))
    else $error("erase prepare not a clean no-data completion");
  unarmed_erase_a: assert property (
    take && cmdCode == sec_cmd_pkg::OP_ERASE_UNIT && !armed_r
    |-> ##2 done && errorFlags[2])
    else $error("unarmed erase unit not aborted");
  bad_opcode_a: assert property (
    take && !known |-> ##2 done && errorFlags[2])
    else $error("unsupported opcode not aborted");
  abort_flags_a: assert property (
    done && errorFlags[2] |-> statusFlags == 8'h51 && errorFlags == 8'h04)
    else $error("abort flags wrong");
  success_clean_a: assert property (
    done && !errorFlags[2] |-> errorFlags == 8'h00 && statusFlags == 8'h50)
    else $error("completion flags wrong");
  drq_cause_a: assert property (
    $rose(dataReq) |-> $past(take) && $past(cmdCode) == 8'hF6)
    else $error("data request without disable opcode");
  done_pulse_a: assert property (
    done |-> $past(busy) && !$past(done))
    else $error("done not a single pulse after busy");
  reserved_zero_a: assert property (
    wordValid && dataReq && wordCnt_r > 9'h010 |-> wordData == 16'h0000)
    else $error("reserved sector word not zero");
endmodule
`default_nettype wire

// ---- test/tb_security_password_disable_and_erase_prep.sv ----
// self-checking bench for the controller and drive pair
`timescale 1ns/100ps
`default_nettype none
module tb_security_password_disable_and_erase_prep;
  localparam logic [255:0] USER_PWD   = {8{32'hC0DE1234}};
  localparam logic [255:0] MASTER_PWD = {8{32'h5EC00A7B}};
  // erase order, first command in the top byte; abort flags in step
  localparam logic [47:0]  ERASE_OPS  = 48'hF4F3F4F3E7F4;
  localparam logic [5:0]   ERASE_ABT  = 6'h23;
  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [5:0]  wbAdr  = 6'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic        wbAck, irq, lockOn, eraseGo;
  logic        lockSet = 1'b0;
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, erases = 0;

  sec_cmd_if sec_cmd_if_inst ();
  sec_cmd_drive sec_cmd_drive_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(sec_cmd_if_inst), .userPwd(USER_PWD), .masterPwd(MASTER_PWD),
    .lockSet(lockSet), .lockOn(lockOn), .eraseGo(eraseGo));
  sec_cmd_ctrl sec_cmd_ctrl_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .link(sec_cmd_if_inst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .irq(irq));
  sec_cmd_asserts sec_cmd_asserts_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .cmdValid(sec_cmd_if_inst.cmdValid), .cmdCode(sec_cmd_if_inst.cmdCode),
    .wordValid(sec_cmd_if_inst.wordValid), .wordData(sec_cmd_if_inst.wordData),
    .busy(sec_cmd_if_inst.busy), .dataReq(sec_cmd_if_inst.dataReq),
    .done(sec_cmd_if_inst.done), .errorFlags(sec_cmd_if_inst.errorFlags),
    .statusFlags(sec_cmd_if_inst.statusFlags));

  // 40 MHz clock
  always #12.5 ref_clk = ~ref_clk;

  // counts erase pulses and cuts a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (eraseGo === 1'b1)
      erases++;
    if (cycles == 40000) begin
      n_mismatch++;
      $display("ERROR t=%0t timeout cycles=%h limit=%h", $time, cycles, 40000);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one classic cycle: hold until ack at a rising edge, release there
  task automatic wbXfer(input logic w, input logic [5:0] a,
                        input logic [31:0] d, output logic [31:0] q);
    {wbCyc, wbStb, wbWe, wbAdr, wbDatI} <= {2'h3, w, a, d};
    do @(posedge ref_clk); while (wbAck !== 1'b1);
    q = wbDatO;
    {wbCyc, wbStb} <= 2'h0;
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wbXfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wbXfer(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask

  task automatic pulseLock();
    lockSet <= 1'b1;
    @(posedge ref_clk);
    lockSet <= 1'b0;
    @(posedge ref_clk);
  endtask

  // loads password and control word, issues an opcode, checks the outcome
  task automatic runCmd(input logic [7:0] op, input logic [15:0] ctl,
                        input logic [255:0] pwd, input logic abort);
    int k;
    for (int i = 0; i < 8; i++)
      wr(sec_cmd_pkg::REG_PWD_BASE + 6'(4 * i), pwd[32 * i +: 32]);
    wr(sec_cmd_pkg::REG_CTRLWORD, {16'h0000, ctl});
    wr(sec_cmd_pkg::REG_COMMAND, {24'h000000, op});
    k = 0;
    while (irq !== 1'b1 && k < 600) begin
      @(posedge ref_clk);
      k++;
    end
    check({31'h0, irq}, 32'h1);
    rd(sec_cmd_pkg::REG_RESULT, abort ? 32'h00000451 : 32'h00000050);
    rd(sec_cmd_pkg::REG_IRQ_STAT, {30'h0, abort, 1'b1});
    wr(sec_cmd_pkg::REG_IRQ_STAT, 32'h3);
    @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    $display("test done op=%h ctl=%h", op, ctl);
  endtask

  // main sequence
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(sec_cmd_pkg::REG_IRQ_STAT, 32'h0);
    wr(6'h18, 32'hFFFFFFFF);
    rd(6'h18, 32'h0);
    wr(sec_cmd_pkg::REG_IRQ_MASK, 32'h3);
    rd(sec_cmd_pkg::REG_IRQ_MASK, 32'h3);
    pulseLock();
    runCmd(8'hF6, 16'hFFFE, ~USER_PWD, 1'b1);
    check({31'h0, lockOn}, 32'h1);
    runCmd(8'hF6, 16'h0001, MASTER_PWD ^ {16'h0001, 240'h0}, 1'b1);
    check({31'h0, lockOn}, 32'h1);
    runCmd(8'hF6, 16'h8001, MASTER_PWD, 1'b0);
    check({31'h0, lockOn}, 32'h0);
    runCmd(8'hF6, 16'h0000, USER_PWD, 1'b1);
    runCmd(8'hF6, 16'h0001, MASTER_PWD, 1'b0);
    pulseLock();
    runCmd(8'hF6, 16'hFFFE, USER_PWD, 1'b0);
    check({31'h0, lockOn}, 32'h0);
    for (int i = 5; i >= 0; i--)
      runCmd(ERASE_OPS[8*i +: 8], 16'h0, USER_PWD, ERASE_ABT[i]);
    check(32'(erases), 32'h1);
    wr(sec_cmd_pkg::REG_IRQ_MASK, 32'h0);
    wr(sec_cmd_pkg::REG_COMMAND, {24'h000000, sec_cmd_pkg::OP_ERASE_PREP});
    rd(sec_cmd_pkg::REG_RESULT, 32'h00010451);
    repeat (10) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    rd(sec_cmd_pkg::REG_IRQ_STAT, 32'h1);
    wr(sec_cmd_pkg::REG_IRQ_STAT, 32'h3);
    rd(sec_cmd_pkg::REG_IRQ_STAT, 32'h0);
    $display("test done masked interrupt");
    print_verdict();
  end
endmodule
`default_nettype wire
